/* pesr_pkg.sv */
/*
  Shared constants, field positions and helpers for the protected serial
  EEPROM slave. Assumes a 25 MHz core clock and a free-running link clock
  that oversamples the two-wire bus.
*/
package pesr_pkg;

  // ***************************************************************
  // Device address decode
  // ***************************************************************
  localparam logic [4:0] DEV_MAIN_CODE = 5'h15; // Main array codes.
  localparam logic [6:0] DEV_PAGE_CODE = 7'h5c; // Protection and ID page.

  // ***************************************************************
  // Memory organisation
  // ***************************************************************
  localparam int MEM_BYTES = 1024;       // Eight blocks of 128 bytes.
  localparam int PAGE_BYTES = 16;        // Bytes in one write page.
  localparam int SIDE_BYTES = 32;        // Protection page plus ID page.
  localparam logic [7:0] ERASED_BYTE = 8'hff; // Delivered erased value.
  localparam logic [4:0] MAX_WRITE = 5'h10;   // Bytes buffered per write.
  localparam logic [3:0] BIT_LAST = 4'h8;     // Bits in one byte.
  localparam logic [2:0] PAGE_HI_ZERO = 3'h0; // Side page address top.
  localparam logic [4:0] PP_CTRL_IDX = 5'h08; // Byte holding page gate.
  localparam logic [4:0] PP_GATED_FIRST = 5'h09; // First gated byte.

  // ***************************************************************
  // Field layout of a per-block protection byte
  // ***************************************************************
  localparam int PERM_LSB = 0;  // Access permission field, low bit.
  localparam int PERM_MSB = 1;  // Access permission field, high bit.
  localparam int RADIO_LSB = 2; // Radio permission field, low bit.
  localparam int RADIO_MSB = 3; // Radio permission field, high bit.
  localparam logic [1:0] PERM_RW = 2'h3; // Free read and write.

  // ***************************************************************
  // Erase/write timing
  // ***************************************************************
  localparam int EW_TIME_US = 5000;   // Erase/write cycle, microseconds.
  localparam int CLK_MHZ = 25;        // Core clock rate.
  localparam int EW_CYCLES = EW_TIME_US * CLK_MHZ; // Core cycles busy.
  localparam int EW_CNT_W = 17;       // Width of the busy counter.

  // ***************************************************************
  // Interface state machine
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK
  } pesr_state_t;

  typedef enum logic [1:0] {
    K_DEV, K_WORD, K_DATA
  } pesr_kind_t;

  // Reads are allowed whenever the high bit of the field is set.
  function automatic logic perm_can_read(input logic [1:0] f);
    perm_can_read = f[1];
  endfunction

  // Writes need both bits of the field set.
  function automatic logic perm_can_write(input logic [1:0] f);
    perm_can_write = (f == PERM_RW);
  endfunction

endpackage

/* pesr_sync.sv */
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes each bit is a level that may change at any time relative to clk.
*/
`timescale 1ns/10ps

module pesr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage; read only by the second stage.
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // ***************************************************************
  // Next values
  // ***************************************************************
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end

endmodule // pesr_sync

/* pesr_ewtimer.sv */
/*
  Self-timed erase/write cycle timer on the core clock.
  Assumes go_toggle comes from the link domain and flips once per cycle
  to be started; busy is a level fed back to the link side.
*/
`timescale 1ns/10ps

module pesr_ewtimer
  import pesr_pkg::*;
#(
  parameter int EW_COUNT = pesr_pkg::EW_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go_toggle,
  output logic busy
);

  // Toggle crossing: t1 is read only by t2, the edge uses t2 and t3.
  logic t1_ff;
  logic t2_ff;
  logic t3_ff;
  logic [EW_CNT_W-1:0] cnt_ff; // Cycles left in the busy period.
  logic [EW_CNT_W-1:0] nxt_cnt;
  logic nxt_busy;
  logic go_evt;

  // ***************************************************************
  // Busy period countdown
  // ***************************************************************
  // A new request while busy cannot occur, because the link side
  // refuses every address byte until busy has been seen low.
  always_comb begin
    go_evt = t2_ff ^ t3_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy;
    if (go_evt) begin
      nxt_cnt = EW_CNT_W'(EW_COUNT - 1);
      nxt_busy = 1'b1;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - EW_CNT_W'(1);
    end else begin
      nxt_busy = 1'b0; // Timer ends the busy period.
    end
  end

  // No cycle is pending after reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t1_ff <= 1'b0;
      t2_ff <= 1'b0;
      t3_ff <= 1'b0;
      cnt_ff <= '0;
      busy <= 1'b0;
    end else begin
      t1_ff <= go_toggle;
      t2_ff <= t1_ff;
      t3_ff <= t2_ff;
      cnt_ff <= nxt_cnt;
      busy <= nxt_busy;
    end
  end

endmodule // pesr_ewtimer

/* pesr_slave.sv */
/*
  Two-wire slave front end of a 1024-byte EEPROM with per-block access
  permissions, a write-protect pin and a self-timed erase/write cycle.
  Assumes link_clk oversamples scl and sda at least four times per bus
  clock phase and runs freely; the pad combines sda_oe into the wire.
*/
`timescale 1ns/10ps

// What this block does
// - Shift every byte most significant bit first.
// - Eight blocks, eight 16-byte pages each.
// - Unwritten bits read as one.
// - Address byte last bit: one read, zero write.
// - Write address byte carries the top two address bits.
// - Answer main array only at codes A8h to AFh.
// - Write-protect pin high refuses all writes.
// - Protected writes still load the address pointer.
// - Acknowledge word address and data, advance address.
// - Split address into block, page and offset.
// - Program buffered bytes only after a stop.
// - Page write advances low four bits only.
// - Seventeenth byte refused, whole write discarded.
// - Erase/write cycle lasts 5 ms by timer.
// - No acknowledge to any address while busy.
// - Reads wrap within the current 128-byte block.
// - Protection bytes sit in a separate page.
// - Forbidden access is refused by not-acknowledge; reads are checked at their start address only.
// - Field: high zero none, 10 read, 11 both.
// - Keep radio field, return it, no effect.
// - Codes B8h/B9h reach protection and ID page.
// - Forbidden write: acknowledge addresses, refuse data.
module pesr_slave
  import pesr_pkg::*;
#(
  parameter int EW_COUNT = pesr_pkg::EW_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  output logic busy
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [2:0] pins_s;         // Synchronised scl, sda and protect pin.
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic scl_d_ff;             // Previous scl sample.
  logic sda_d_ff;             // Previous sda sample.
  logic busy_s;               // Busy level from the core domain.
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic link_busy;
  logic commit;               // Program the buffer this cycle.

  pesr_state_t st_ff, nxt_st;
  pesr_kind_t kind_ff, nxt_kind;
  logic [7:0] shift_ff, nxt_shift;   // Byte being moved on the bus.
  logic [3:0] cnt_ff, nxt_cnt;       // Bits moved in this byte.
  logic oe_ff, nxt_oe;               // Pulling sda low.
  logic ack_ff, nxt_ack;             // Acknowledge given or received.
  logic rd_ff, nxt_rd;               // Current transfer is a read.
  logic psel_ff, nxt_psel;           // Side pages selected.
  logic [9:0] addr_ff, nxt_addr;     // Main array pointer.
  logic [4:0] paddr_ff, nxt_paddr;   // Side page pointer.
  logic [15:0] mask_ff, nxt_mask;    // Buffered byte positions.
  logic [4:0] nbytes_ff, nxt_nbytes; // Data bytes taken.
  logic wok_ff, nxt_wok;             // Write permitted so far.
  logic abort_ff, nxt_abort;         // Write overflowed its page.
  logic pend_ff, nxt_pend;           // Cycle started, busy not seen yet.
  logic go_ff, nxt_go;               // Toggles once per started cycle.
  logic [7:0] rdata;
  logic [7:0] wbuf_ff [0:PAGE_BYTES-1];
  logic [7:0] nxt_wbuf [0:PAGE_BYTES-1];
  logic [7:0] mem_ff [0:MEM_BYTES-1];   // Main array.
  logic [7:0] nxt_mem [0:MEM_BYTES-1];
  logic [7:0] pp_ff [0:SIDE_BYTES-1];   // Protection and ID page.
  logic [7:0] nxt_pp [0:SIDE_BYTES-1];

  // ***************************************************************
  // Crossings
  // ***************************************************************
  pesr_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in, write_protect}),
    .sync_out(pins_s)
  );

  pesr_sync #(
    .WIDTH(1)
  ) u_busy_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .async_in(busy),
    .sync_out(busy_s)
  );

  pesr_ewtimer #(
    .EW_COUNT(EW_COUNT)
  ) u_ewtimer (
    .clk(clk),
    .reset_n(reset_n),
    .go_toggle(go_ff),
    .busy(busy)
  );

  // ***************************************************************
  // Bus condition detection
  // ***************************************************************
  // Both lines are sampled together, so start and stop are seen as an
  // sda edge while scl stays high.
  always_comb begin
    scl_s = pins_s[2];
    sda_s = pins_s[1];
    wp_s = pins_s[0];
    start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    rise_c = scl_s & ~scl_d_ff;
    fall_c = ~scl_s & scl_d_ff;
    // The local flag covers the crossing delay before busy comes back.
    link_busy = pend_ff | busy_s;
    // Read data from the side pages or the main array.
    rdata = psel_ff ? pp_ff[paddr_ff] : mem_ff[addr_ff];
  end

  // ***************************************************************
  // Protocol engine
  // ***************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_kind = kind_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_oe = oe_ff;
    nxt_ack = ack_ff;
    nxt_rd = rd_ff;
    nxt_psel = psel_ff;
    nxt_addr = addr_ff;
    nxt_paddr = paddr_ff;
    nxt_mask = mask_ff;
    nxt_nbytes = nbytes_ff;
    nxt_wok = wok_ff;
    nxt_abort = abort_ff;
    nxt_wbuf = wbuf_ff;
    commit = 1'b0;
    if (start_c) begin
      // Start or repeated start: drop any partial byte.
      nxt_st = ST_RX;
      nxt_kind = K_DEV;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_abort = 1'b0;
      nxt_nbytes = 5'h00;
      nxt_mask = 16'h0000;
      nxt_wok = 1'b0;
    end else if (stop_c) begin
      nxt_st = ST_IDLE;
      nxt_oe = 1'b0;
      // Only a stop after good data bytes programs anything.
      commit = wok_ff & ~abort_ff & ~rd_ff & (nbytes_ff != 5'h00);
      nxt_wok = 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ST_RX: begin
          if (rise_c && cnt_ff != BIT_LAST) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (fall_c && cnt_ff == BIT_LAST) begin
            nxt_st = ST_ACK;
            nxt_ack = 1'b0;
            unique case (kind_ff)
              K_DEV: begin
                // Busy refuses every address byte.
                if (!link_busy && shift_ff[7:3] == DEV_MAIN_CODE) begin
                  nxt_rd = shift_ff[0];
                  nxt_psel = 1'b0;
                  if (!shift_ff[0]) begin
                    nxt_addr[9:8] = shift_ff[2:1];
                    nxt_ack = 1'b1;
                  end else begin
                    // Read refused if block field forbids it.
                    nxt_ack = perm_can_read(
                      pp_ff[{2'b00, addr_ff[9:7]}][PERM_MSB:PERM_LSB]);
                  end
                end else if (!link_busy &&
                             shift_ff[7:1] == DEV_PAGE_CODE) begin
                  nxt_rd = shift_ff[0];
                  nxt_psel = 1'b1;
                  if (!shift_ff[0] || paddr_ff < PP_GATED_FIRST) begin
                    nxt_ack = 1'b1;
                  end else begin
                    nxt_ack = perm_can_read(
                      pp_ff[PP_CTRL_IDX][PERM_MSB:PERM_LSB]);
                  end
                end
              end
              K_WORD: begin
                nxt_nbytes = 5'h00;
                nxt_mask = 16'h0000;
                if (psel_ff) begin
                  // Only 00h to 1Fh exist in the side pages.
                  if (shift_ff[7:5] == PAGE_HI_ZERO) begin
                    nxt_ack = 1'b1;
                    nxt_paddr = shift_ff[4:0];
                    nxt_wok = ~wp_s & ((shift_ff[4:0] < PP_GATED_FIRST) |
                      perm_can_write(pp_ff[PP_CTRL_IDX][PERM_MSB:PERM_LSB]));
                  end
                end else begin
                  // Pointer loads even when writing is barred.
                  nxt_ack = 1'b1;
                  nxt_addr[7:0] = shift_ff;
                  nxt_wok = ~wp_s & perm_can_write(
                    pp_ff[{2'b00, addr_ff[9:8], shift_ff[7]}]
                      [PERM_MSB:PERM_LSB]);
                end
              end
              K_DATA: begin
                if (nbytes_ff == MAX_WRITE ||
                    (psel_ff && nbytes_ff != 5'h00)) begin
                  nxt_abort = 1'b1; // Overflow discards the write.
                end else if (wok_ff) begin
                  nxt_ack = 1'b1;
                  nxt_nbytes = nbytes_ff + 5'h01;
                  if (psel_ff) begin
                    nxt_wbuf[0] = shift_ff;
                  end else begin
                    nxt_wbuf[addr_ff[3:0]] = shift_ff;
                    nxt_mask[addr_ff[3:0]] = 1'b1;
                    nxt_addr[3:0] = addr_ff[3:0] + 4'h1;
                  end
                end
                // A barred write refuses its data bytes.
              end
              default: begin
                nxt_ack = 1'b0;
              end
            endcase
            nxt_oe = nxt_ack;
          end
        end
        ST_ACK: begin
          if (fall_c) begin
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
            if (!ack_ff) begin
              nxt_st = ST_IDLE; // Wait for the master's stop.
            end else if (kind_ff == K_DEV && rd_ff) begin
              nxt_st = ST_TX;
              nxt_shift = rdata;
              nxt_oe = ~rdata[7];
            end else begin
              nxt_st = ST_RX;
              nxt_kind = (kind_ff == K_DEV) ? K_WORD : K_DATA;
            end
          end
        end
        ST_TX: begin
          if (rise_c && cnt_ff != BIT_LAST) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (fall_c && cnt_ff == BIT_LAST) begin
            nxt_oe = 1'b0;
            nxt_st = ST_TACK;
            if (psel_ff) begin
              nxt_paddr = paddr_ff + 5'h01;
            end else begin
              nxt_addr[6:0] = addr_ff[6:0] + 7'h01;
            end
          end else if (fall_c && cnt_ff != 4'h0) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        ST_TACK: begin
          if (rise_c) begin
            nxt_ack = ~sda_s;
          end else if (fall_c) begin
            nxt_cnt = 4'h0;
            if (ack_ff) begin
              nxt_st = ST_TX;
              nxt_shift = rdata;
              nxt_oe = ~rdata[7];
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Cycle start hand-off
  // ***************************************************************
  // The pending flag holds the bus off until busy arrives from the core.
  always_comb begin
    nxt_go = go_ff ^ commit;
    nxt_pend = pend_ff;
    if (commit) begin
      nxt_pend = 1'b1;
    end else if (busy_s) begin
      nxt_pend = 1'b0;
    end
  end

  // ***************************************************************
  // Array programming
  // ***************************************************************
  // Bytes land at the stop; the bus stays refused for the whole cycle,
  // so no read can observe the write before it is timed out.
  always_comb begin
    nxt_mem = mem_ff;
    nxt_pp = pp_ff;
    if (commit && !psel_ff) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_ff[i]) begin
          nxt_mem[{addr_ff[9:4], 4'(i)}] = wbuf_ff[i];
        end
      end
    end else if (commit) begin
      // Radio bits are stored and read back, never consulted.
      nxt_pp[paddr_ff] = wbuf_ff[0];
    end
  end

  // ***************************************************************
  // Link domain registers
  // ***************************************************************
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      st_ff <= ST_IDLE;
      kind_ff <= K_DEV;
      shift_ff <= 8'h00;
      cnt_ff <= 4'h0;
      oe_ff <= 1'b0;
      ack_ff <= 1'b0;
      rd_ff <= 1'b0;
      psel_ff <= 1'b0;
      addr_ff <= 10'h000;
      paddr_ff <= 5'h00;
      mask_ff <= 16'h0000;
      nbytes_ff <= 5'h00;
      wok_ff <= 1'b0;
      abort_ff <= 1'b0;
      pend_ff <= 1'b0;
      go_ff <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        wbuf_ff[i] <= 8'h00;
      end
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_ff[i] <= ERASED_BYTE;
      end
      for (int i = 0; i < SIDE_BYTES; i++) begin
        pp_ff[i] <= ERASED_BYTE;
      end
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      st_ff <= nxt_st;
      kind_ff <= nxt_kind;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      oe_ff <= nxt_oe;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
      psel_ff <= nxt_psel;
      addr_ff <= nxt_addr;
      paddr_ff <= nxt_paddr;
      mask_ff <= nxt_mask;
      nbytes_ff <= nxt_nbytes;
      wok_ff <= nxt_wok;
      abort_ff <= nxt_abort;
      pend_ff <= nxt_pend;
      go_ff <= nxt_go;
      sda_out <= 1'b0; // Open drain: only ever pulls low.
      sda_oe <= nxt_oe;
      wbuf_ff <= nxt_wbuf;
      mem_ff <= nxt_mem;
      pp_ff <= nxt_pp;
    end
  end

endmodule // pesr_slave

/* pesr_master.sv */
/* Two-wire bus master model that stands on the far side of pesr_slave.
   Assumes a pull-up on sda; link_clk only paces the bit phases. */
`timescale 1ns/10ps
module pesr_master (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic pull = 1'b0
);
  // One third of a bit; scl low lasts eight link_clk cycles, above five.
  task automatic ph(input logic s, input logic p);
    scl = s;
    pull = p;
    repeat (4) @(negedge link_clk);
  endtask
  // From idle or mid-frame; the second use is a repeated start.
  task automatic start();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // Data moves only while scl is low and is sampled late in scl high.
  task automatic bitx(input logic b, output logic v);
    ph(1'b0, !b);
    ph(1'b1, !b);
    v = sda;
    ph(1'b0, !b);
  endtask
  // Byte out then ninth bit; m high releases sda for the answer.
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] r, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(m, b);
    a = !b;
  endtask
endmodule // pesr_master

/* pesr_slave_sva.sv */
/* Port checker for pesr_slave, bound into every instance.
   Assumes sda is pulled up outside and busy runs on clk. */
`timescale 1ns/10ps
module pesr_slave_sva #(
  parameter int EW_COUNT = 200
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic busy
);
  logic [16:0] nxt_busy_cnt; // Counting busy cycles catches a short timer.
  logic [16:0] busy_cnt_ff;
  always_comb begin
    nxt_busy_cnt = busy ? busy_cnt_ff + 17'h1 : 17'h0;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_cnt_ff <= 17'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  pad_open_a: assert property (
    @(posedge link_clk) disable iff (!reset_n) sda_out == 1'b0)
    else $error("sda_out not low");
  bit_hold_a: assert property (
    @(posedge link_clk) disable iff (!reset_n) $changed(sda_oe) |-> !scl_in)
    else $error("sda moved with scl high");
  busy_quiet_a: assert property (
    @(posedge link_clk) disable iff (!reset_n) busy |-> !sda_oe)
    else $error("answer while busy");
  busy_len_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(busy) |-> busy_cnt_ff == EW_COUNT) else $error("busy length");
  busy_min_a: assert property (
    @(posedge clk) disable iff (!reset_n) $rose(busy) |=> busy[*8])
    else $error("busy too short");
  busy_stop_a: assert property (
    @(posedge clk) disable iff (!reset_n) $rose(busy) |-> scl_in && sda_in)
    else $error("busy without stop");
  wp_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n) $rose(busy) |-> !write_protect)
    else $error("program while protected");
  reset_idle_a: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !sda_oe && !busy) else $error("not idle at reset");
  cover property (@(posedge clk) $rose(busy));
  cover property (@(posedge clk) $fell(busy));
  cover property (@(posedge link_clk) $rose(sda_oe));
endmodule // pesr_slave_sva
bind pesr_slave pesr_slave_sva #(.EW_COUNT(EW_COUNT)) chk_i (
  .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect(write_protect), .busy(busy));

/* test_pesr_slave.sv */
/* Self-checking bench for pesr_slave driven through pesr_master.
   Assumes a pulled-up sda wire and a shortened erase/write cycle. */
`timescale 1ns/10ps
module test_pesr_slave;
  localparam int EWC = 400; // Long enough to address the busy device.
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_protect = 1'b0;
  logic scl, pull, sda, sda_oe, sda_out, busy, a;
  logic [7:0] r, v;
  int failures = 0;
  int cmp_count = 0;
  // Rows: device code, word address, byte written and read back.
  logic [23:0] rows [4] = '{24'ha8003c, 24'haa3596, 24'hae805a, 24'haeffc3};
  assign sda = !(sda_oe || pull); // Wired-and with pull-up.
  always #20 clk = ~clk;
  always #32 link_clk = ~link_clk;
  pesr_slave #(.EW_COUNT(EWC)) uut (.clk(clk), .reset_n(reset_n),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect), .busy(busy));
  pesr_master m (.link_clk(link_clk), .sda(sda), .scl(scl), .pull(pull));
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic sb(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, r, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    m.xfer(8'hff, last, r, a);
    chk("data", e, r);
  endtask
  // Gives busy time to rise first, since the start of it is refused too.
  task automatic idle();
    repeat (20) @(negedge clk);
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge clk);
    chk("busy", 8'h0, {7'h0, busy});
  endtask
  task automatic wr(input logic [7:0] dv, w, d, input logic e);
    m.start();
    sb(dv, 1'b1);
    sb(w, 1'b1);
    sb(d, e);
    m.stop();
    idle();
  endtask
  // Random read: pointer load, repeated start, one byte.
  task automatic rd(input logic [7:0] dv, w, e, input logic ea);
    m.start();
    sb(dv, 1'b1);
    sb(w, 1'b1);
    m.start();
    sb(dv | 8'h01, ea);
    if (ea) rb(e, 1'b1);
    m.stop();
  endtask
  initial begin
    #3000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge link_clk);
    rd(8'ha8, 8'h40, 8'hff, 1'b1);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8], rows[i][7:0], 1'b1);
      rd(rows[i][23:16], rows[i][15:8], rows[i][7:0], 1'b1);
    end
    m.start();
    sb(8'hae, 1'b1);
    sb(8'hff, 1'b1);
    m.start();
    sb(8'haf, 1'b1);
    rb(8'hc3, 1'b0);
    rb(8'h5a, 1'b1);
    m.stop();
    m.start();
    sb(8'haa, 1'b1);
    sb(8'h3e, 1'b1);
    for (int i = 0; i < 3; i++) sb(8'h11 * (i + 1), 1'b1);
    m.stop();
    repeat (20) @(negedge clk);
    m.start();
    sb(8'ha8, 1'b0);
    m.stop();
    idle();
    rd(8'haa, 8'h3f, 8'h22, 1'b1);
    rd(8'haa, 8'h30, 8'h33, 1'b1);
    m.start();
    sb(8'hac, 1'b1);
    sb(8'h00, 1'b1);
    for (int i = 0; i < 17; i++) sb(8'h55, i < 16);
    m.stop();
    idle();
    rd(8'hac, 8'h00, 8'hff, 1'b1);
    write_protect = 1'b1;
    wr(8'haa, 8'h35, 8'h77, 1'b0);
    rd(8'haa, 8'h35, 8'h96, 1'b1);
    write_protect = 1'b0;
    for (int f = 0; f < 4; f++) begin
      v = 8'ha0 | 8'(f) | 8'(f << 2);
      // Side byte 02h gates block 2, which holds main address 135h.
      wr(8'hb8, 8'h02, v, 1'b1);
      rd(8'hb8, 8'h02, v, 1'b1);
      wr(8'haa, 8'h35, 8'h66, f == 3);
      rd(8'haa, 8'h35, (f == 3) ? 8'h66 : 8'h96, f > 1);
    end
    m.start();
    sb(8'ha0, 1'b0);
    m.start();
    sb(8'hb8, 1'b1);
    sb(8'h20, 1'b0);
    m.stop();
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge link_clk);
    rd(8'ha8, 8'h00, 8'hff, 1'b1);
    wrap_up();
  end
endmodule // test_pesr_slave
